// >>> rtl/addr_decode_defs.svh
// register offsets, field positions, reset values and timing counts of the address decoder
`ifndef ADDR_DECODE_DEFS_SVH
`define ADDR_DECODE_DEFS_SVH

// ==========================================
// register indices (byte address = index * 4)
`define IDX_PART_IDENT_HIGH  8'h1A
`define IDX_PART_IDENT_LOW   8'h1B
`define IDX_MAP_CONTROL_ONE  8'h10
`define IDX_CLOCK_CONTROL    8'h11
`define IDX_FLASH_PRESCALE   8'h12
`define IDX_MODE_STATUS      8'h13
`define IDX_IRQ_STATUS       8'h14
`define IDX_IRQ_MASK         8'h15

// ==========================================
// field positions
`define BIT_INFO_ROW_ON      0
`define BIT_CLK_SRC_OSC      0
`define BIT_MON_RESET_EN     1
`define BIT_EVT_ILLEGAL      0
`define BIT_EVT_OSC_LOST     1
`define BIT_EVT_RSVD_WRITE   2

// ==========================================
// reset values
`define RST_MAP_CONTROL_ONE  8'h00
`define RST_CLOCK_CONTROL    8'h00
`define RST_FLASH_PRESCALE   8'h09
`define RST_IRQ_MASK         8'h00

// ==========================================
// global memory map (18-bit global address)
`define GA_REG_TOP           18'h003FF
`define GA_INFO_BOT          18'h00400
`define GA_INFO_TOP          18'h0047F
`define GA_RAM_BOT           18'h00800
`define GA_RAM_BASE_M1       18'h007FF
`define GA_FLASH_END_P1      19'h40000
`define GA_FLASH_TOP         18'h3FFFF
`define RAM_BYTE_COUNT       18'h00800
`define FLASH_BYTE_COUNT     19'h08000

// ==========================================
// timing
`define MCLK_PERIOD_NS       100
`define OSC_MON_TIMEOUT_NS   100000
`define OSC_MON_CYCLES       (`OSC_MON_TIMEOUT_NS / `MCLK_PERIOD_NS)
`define MODE_CAPTURE_CYCLES  2'd3

`endif

// >>> rtl/addr_decode_pkg.sv
// types shared by the address decoder files
package addr_decode_pkg;

  typedef enum logic [2:0] {
    TGT_NONE    = 3'b000,
    TGT_REG     = 3'b001,
    TGT_INFO    = 3'b010,
    TGT_RAM     = 3'b011,
    TGT_FLASH   = 3'b100,
    TGT_RSVD    = 3'b101,
    TGT_ILLEGAL = 3'b110
  } target_t;

  typedef enum logic {
    SRC_FLL = 1'b0,
    SRC_OSC = 1'b1
  } clk_src_t;

endpackage

// >>> rtl/sync_two_ff.sv
// two flip-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ns
`default_nettype none

module sync_two_ff #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/tick_divider.sv
// divider that turns the bus clock into a one-cycle enable every (div + 1) cycles
`timescale 1ns/1ns
`default_nettype none

module tick_divider (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // control
  input  wire logic [7:0] div,
  output var  logic       tick
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       tick_d;

  always_comb begin
    tick_d = (cnt_q >= div);
    cnt_d  = tick_d ? 8'h00 : cnt_q + 8'h01;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/global_addr_decode.sv
// global address decoder with part identification, clock source and oscillator monitor
`timescale 1ns/1ns
`default_nettype none
`include "addr_decode_defs.svh"

module global_addr_decode #(
  parameter logic [3:0] ID_MAJOR_FAMILY = 4'h5, // arbitrary value
  parameter logic [3:0] ID_MINOR_FAMILY = 4'hA, // arbitrary value
  parameter logic [3:0] ID_MAJOR_MASK   = 4'h1, // arbitrary value
  parameter logic [3:0] ID_MINOR_MASK   = 4'h2  // arbitrary value
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // ahb-lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output var  logic                     hreadyout,
  output var  logic                     hresp,
  output var  logic [31:0]              hrdata,
  // cpu and debug access to decode
  input  wire logic                     acc_valid,
  input  wire logic                     acc_write,
  input  wire logic [17:0]              acc_addr,
  input  wire logic [15:0]              tgt_rdata,
  output var  addr_decode_pkg::target_t acc_target,
  output var  logic                     sel_reg,
  output var  logic                     sel_info,
  output var  logic                     sel_ram,
  output var  logic                     sel_flash,
  output var  logic                     acc_wr_en,
  output var  logic [15:0]              acc_rdata,
  // pins
  input  wire logic                     mode_select_input,
  input  wire logic                     osc_heartbeat,
  // system
  output var  addr_decode_pkg::clk_src_t sys_clk_src,
  output var  logic                     flash_time_tick,
  output var  logic                     mode_normal,
  output var  logic                     sys_reset_req,
  output var  logic                     irq
);
  import addr_decode_pkg::*;

  localparam logic [10:0] MON_LIMIT = 11'(`OSC_MON_CYCLES);

  // ==========================================
  // synchronised pins
  logic [1:0] pin_sync;

  sync_two_ff #(.W(2)) u_pin_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({osc_heartbeat, mode_select_input}),
    .sync_out (pin_sync)
  );

  // ==========================================
  // register file state
  logic [7:0]  map_ctl_q, map_ctl_d;
  logic [7:0]  clk_ctl_q, clk_ctl_d;
  logic [7:0]  prescale_q, prescale_d;
  logic [7:0]  irq_stat_q, irq_stat_d;
  logic [7:0]  irq_mask_q, irq_mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_idx_q, wr_idx_d;
  logic [15:0] part_id;
  logic        addr_phase;
  logic        addr_mapped;
  logic [7:0]  addr_idx;
  logic [7:0]  events;

  assign part_id = {ID_MAJOR_FAMILY, ID_MINOR_FAMILY, ID_MAJOR_MASK, ID_MINOR_MASK};

  assign addr_phase  = hsel && hready && htrans[1];
  assign addr_idx    = haddr[9:2];
  assign addr_mapped = (haddr[31:10] == 22'h000000);
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = rdata_q;

  // ==========================================
  // address decode
  target_t     tgt;
  logic [18:0] flash_low;
  logic [18:0] ram_top;

  always_comb begin
    ram_top   = {1'b0, `GA_RAM_BASE_M1} + {1'b0, `RAM_BYTE_COUNT};
    flash_low = `GA_FLASH_END_P1 - `FLASH_BYTE_COUNT;
    tgt       = TGT_NONE;
    if (!acc_valid) begin
      tgt = TGT_NONE;
    end else if (acc_addr <= `GA_REG_TOP) begin
      tgt = TGT_REG;
    end else if (acc_addr >= `GA_INFO_BOT && acc_addr <= `GA_INFO_TOP) begin
      tgt = map_ctl_q[`BIT_INFO_ROW_ON] ? TGT_INFO : TGT_RSVD;
    end else if (acc_addr < `GA_RAM_BOT) begin
      tgt = TGT_RSVD;
    end else if ({1'b0, acc_addr} <= ram_top) begin
      tgt = TGT_RAM;
    end else if ({1'b0, acc_addr} >= flash_low && acc_addr <= `GA_FLASH_TOP) begin
      tgt = TGT_FLASH;
    end else begin
      tgt = TGT_ILLEGAL;
    end
  end

  assign acc_target = tgt;
  assign sel_reg    = (tgt == TGT_REG);
  assign sel_info   = (tgt == TGT_INFO);
  assign sel_ram    = (tgt == TGT_RAM);
  assign sel_flash  = (tgt == TGT_FLASH);
  assign acc_wr_en  = acc_write && (sel_reg || sel_info || sel_ram || sel_flash);

  logic [15:0] acc_rdata_d;

  always_comb begin
    acc_rdata_d = (sel_reg || sel_info || sel_ram || sel_flash) ? tgt_rdata : 16'h0000;
  end

  // ==========================================
  // oscillator monitor
  logic        hb_dly_q;
  logic [10:0] mon_cnt_q, mon_cnt_d;
  logic        mon_timeout;

  always_comb begin
    mon_cnt_d = mon_cnt_q;
    if (pin_sync[1] != hb_dly_q) begin
      mon_cnt_d = 11'h000;
    end else if (mon_cnt_q < MON_LIMIT) begin
      mon_cnt_d = mon_cnt_q + 11'h001;
    end
    mon_timeout = (mon_cnt_q == MON_LIMIT - 11'h001) && (mon_cnt_d == MON_LIMIT);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hb_dly_q  <= 1'b0;
      mon_cnt_q <= 11'h000;
    end else begin
      hb_dly_q  <= pin_sync[1];
      mon_cnt_q <= mon_cnt_d;
    end
  end

  // ==========================================
  // mode capture after reset release
  logic [1:0] cap_cnt_q, cap_cnt_d;
  logic       mode_q, mode_d;

  always_comb begin
    cap_cnt_d = cap_cnt_q;
    mode_d    = mode_q;
    if (cap_cnt_q != `MODE_CAPTURE_CYCLES) begin
      cap_cnt_d = cap_cnt_q + 2'd1;
    end
    if (cap_cnt_q == `MODE_CAPTURE_CYCLES - 2'd1) begin
      mode_d = pin_sync[0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_cnt_q <= 2'd0;
      mode_q    <= 1'b0;
    end else begin
      cap_cnt_q <= cap_cnt_d;
      mode_q    <= mode_d;
    end
  end

  assign mode_normal = mode_q;

  // ==========================================
  // events and reset request
  logic rst_req_d;

  always_comb begin
    events = 8'h00;
    events[`BIT_EVT_ILLEGAL]    = (tgt == TGT_ILLEGAL);
    events[`BIT_EVT_OSC_LOST]   = mon_timeout;
    events[`BIT_EVT_RSVD_WRITE] = (tgt == TGT_RSVD) && acc_write;
    rst_req_d = events[`BIT_EVT_ILLEGAL] || (mon_timeout && clk_ctl_q[`BIT_MON_RESET_EN]);
  end

  // ==========================================
  // register bus
  always_comb begin
    map_ctl_d  = map_ctl_q;
    clk_ctl_d  = clk_ctl_q;
    prescale_d = prescale_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    rdata_d    = 32'h00000000;
    wr_pend_d  = addr_phase && hwrite && addr_mapped;
    wr_idx_d   = addr_idx;
    if (wr_pend_q) begin
      unique case (wr_idx_q)
        `IDX_MAP_CONTROL_ONE: map_ctl_d  = hwdata[7:0];
        `IDX_CLOCK_CONTROL:   clk_ctl_d  = hwdata[7:0];
        `IDX_FLASH_PRESCALE:  prescale_d = hwdata[7:0];
        `IDX_IRQ_MASK:        irq_mask_d = hwdata[7:0];
        default:              ;
      endcase
    end
    if (addr_phase && !hwrite && addr_mapped) begin
      unique case (addr_idx)
        `IDX_PART_IDENT_HIGH: rdata_d = {24'h000000, part_id[15:8]};
        `IDX_PART_IDENT_LOW:  rdata_d = {24'h000000, part_id[7:0]};
        `IDX_MAP_CONTROL_ONE: rdata_d = {24'h000000, map_ctl_q};
        `IDX_CLOCK_CONTROL:   rdata_d = {24'h000000, clk_ctl_q};
        `IDX_FLASH_PRESCALE:  rdata_d = {24'h000000, prescale_q};
        `IDX_MODE_STATUS:     rdata_d = {31'h00000000, mode_q};
        `IDX_IRQ_STATUS: begin
          rdata_d    = {24'h000000, irq_stat_q};
          irq_stat_d = 8'h00;
        end
        `IDX_IRQ_MASK:        rdata_d = {24'h000000, irq_mask_q};
        default:              rdata_d = 32'h00000000;
      endcase
    end
    // events win over the read clear
    irq_stat_d = irq_stat_d | events;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      map_ctl_q     <= `RST_MAP_CONTROL_ONE;
      clk_ctl_q     <= `RST_CLOCK_CONTROL;
      prescale_q    <= `RST_FLASH_PRESCALE;
      irq_mask_q    <= `RST_IRQ_MASK;
      irq_stat_q    <= 8'h00;
      rdata_q       <= 32'h00000000;
      wr_pend_q     <= 1'b0;
      wr_idx_q      <= 8'h00;
      acc_rdata     <= 16'h0000;
      sys_reset_req <= 1'b0;
      irq           <= 1'b0;
    end else begin
      map_ctl_q     <= map_ctl_d;
      clk_ctl_q     <= clk_ctl_d;
      prescale_q    <= prescale_d;
      irq_mask_q    <= irq_mask_d;
      irq_stat_q    <= irq_stat_d;
      rdata_q       <= rdata_d;
      wr_pend_q     <= wr_pend_d;
      wr_idx_q      <= wr_idx_d;
      acc_rdata     <= acc_rdata_d;
      sys_reset_req <= rst_req_d;
      irq           <= |(irq_stat_d & irq_mask_d);
    end
  end

  // ==========================================
  // clocks
  // one source for core and bus
  assign sys_clk_src = clk_ctl_q[`BIT_CLK_SRC_OSC] ? SRC_OSC : SRC_FLL;

  tick_divider u_flash_tick (
    .mclk  (mclk),
    .rst_n (rst_n),
    .div   (prescale_q),
    .tick  (flash_time_tick)
  );

endmodule

`default_nettype wire

// >>> bench/global_addr_decode_asserts.sv
// concurrent checks on the address decoder ports
`timescale 1ns/1ns
`default_nettype none
module global_addr_decode_asserts
  import addr_decode_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // access decode
  input wire logic        acc_valid,
  input wire logic [17:0] acc_addr,
  input wire logic [15:0] tgt_rdata,
  input wire target_t     acc_target,
  input wire logic        sel_reg,
  input wire logic        sel_info,
  input wire logic        sel_ram,
  input wire logic        sel_flash,
  input wire logic        acc_wr_en,
  input wire logic [15:0] acc_rdata,
  // system
  input wire logic        flash_time_tick,
  input wire logic        sys_reset_req,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // properties
  rsvd_read_zero_a: assert property (acc_valid && acc_target == TGT_RSVD |=> acc_rdata == 16'h0000)
    else $error("reserved read not zero");
  rsvd_no_write_a: assert property (acc_target == TGT_RSVD |-> !acc_wr_en)
    else $error("reserved write enabled");
  illegal_reset_a: assert property (acc_valid && acc_addr >= 18'h01000 && acc_addr < 18'h38000 |=> sys_reset_req)
    else $error("no reset on illegal access");
  info_window_a: assert property (sel_info |-> acc_addr >= 18'h00400 && acc_addr <= 18'h0047F)
    else $error("info select outside window");
  ram_map_a: assert property (acc_valid |-> sel_ram == (acc_addr >= 18'h00800 && acc_addr <= 18'h00FFF))
    else $error("ram decode wrong");
  ram_data_a: assert property (acc_valid && sel_ram |=> acc_rdata == $past(tgt_rdata))
    else $error("ram read data wrong");
  flash_map_a: assert property (acc_valid |-> sel_flash == (acc_addr >= 18'h38000))
    else $error("flash decode wrong");
  one_target_a: assert property ($onehot0({sel_reg, sel_info, sel_ram, sel_flash}))
    else $error("more than one target");
  tick_period_a: assert property (flash_time_tick |=> !flash_time_tick [*8] ##1 !flash_time_tick
    ##1 flash_time_tick)
    else $error("flash tick period wrong");
  cover property (sys_reset_req);
  cover property (sel_info);
  cover property (irq);
endmodule
bind global_addr_decode global_addr_decode_asserts i_chk (.mclk(mclk), .rst_n(rst_n), .acc_valid(acc_valid),
  .acc_addr(acc_addr), .tgt_rdata(tgt_rdata), .acc_target(acc_target), .sel_reg(sel_reg), .sel_info(sel_info),
  .sel_ram(sel_ram), .sel_flash(sel_flash), .acc_wr_en(acc_wr_en), .acc_rdata(acc_rdata),
  .flash_time_tick(flash_time_tick), .sys_reset_req(sys_reset_req), .irq(irq));
`default_nettype wire

// >>> bench/access_far_side.sv
// model of the memories behind the decoder and of the oscillator pin
`timescale 1ns/1ns
`default_nettype none
module access_far_side (
  // clock
  input  wire logic        mclk,
  // control
  input  wire logic        osc_run,
  input  wire logic        sel_any,
  input  wire logic [17:0] acc_addr,
  // outputs
  output var  logic [15:0] tgt_rdata,
  output var  logic        osc_heartbeat
);
  logic [15:0] churn_q = 16'h0000;
  logic [1:0]  div_q   = 2'h0;
  logic        hb_q    = 1'b0;
  // unselected data bus wanders every cycle
  always_ff @(posedge mclk) begin
    churn_q <= churn_q + 16'h3B1D;
    div_q   <= div_q + 2'h1;
    if (osc_run && div_q == 2'h3) begin
      hb_q <= !hb_q;
    end
  end
  assign osc_heartbeat = hb_q;
  assign tgt_rdata = sel_any ? (acc_addr[15:0] ^ 16'hA5C3) : churn_q;
endmodule
`default_nettype wire

// >>> bench/tb_global_addr_decode.sv
// self-checking bench of the global address decoder
`timescale 1ns/1ns
`default_nettype none
module tb_global_addr_decode;
  import addr_decode_pkg::*;
  logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, acc_valid, acc_write, acc_wr_en, mode_pin, osc_run;
  logic        sel_reg, sel_info, sel_ram, sel_flash, hbeat, tick, mode_normal, rst_req, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [17:0] acc_addr;
  logic [15:0] tgt_rdata, acc_rdata;
  target_t     acc_target;
  clk_src_t    clk_src;
  logic [2:0]  t;
  logic        r, s;
  int          err_count, n_checks, cyc, k;
  localparam logic [17:0] AT[10] = '{18'h00000, 18'h003FF, 18'h00400, 18'h007FF, 18'h00800, 18'h00FFF,
                                     18'h01000, 18'h37FFF, 18'h38000, 18'h3FFFF};
  localparam logic [2:0]  TT[10] = '{3'd1, 3'd1, 3'd5, 3'd5, 3'd3, 3'd3, 3'd6, 3'd6, 3'd4, 3'd4};
  global_addr_decode i_dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr), .tgt_rdata(tgt_rdata),
    .acc_target(acc_target), .sel_reg(sel_reg), .sel_info(sel_info), .sel_ram(sel_ram), .sel_flash(sel_flash),
    .acc_wr_en(acc_wr_en), .acc_rdata(acc_rdata), .mode_select_input(mode_pin), .osc_heartbeat(hbeat),
    .sys_clk_src(clk_src), .flash_time_tick(tick), .mode_normal(mode_normal), .sys_reset_req(rst_req), .irq(irq));
  access_far_side i_far (.mclk(mclk), .osc_run(osc_run), .sel_any(sel_reg | sel_info | sel_ram | sel_flash),
    .acc_addr(acc_addr), .tgt_rdata(tgt_rdata), .osc_heartbeat(hbeat));
  // ==========================================
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= a;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic acc(input logic wr, input logic [17:0] a);
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_write <= wr;
    acc_addr  <= a;
    @(negedge mclk);
    t = acc_target;
    s = acc_wr_en;
    @(posedge mclk);
    acc_valid <= 1'b0;
    @(negedge mclk);
    r = rst_req;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ==========================================
  // tests
  initial begin
    {rst_n, hsel, hwrite, acc_valid, acc_write, haddr, hwdata, htrans, acc_addr} = '0;
    mode_pin = 1'b1;
    osc_run  = 1'b1;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    hsel  <= 1'b1;
    for (k = 0; k < 10; k++) begin
      acc(1'b0, AT[k]);
      check(t, TT[k]);
      check(acc_rdata, (TT[k] < 5) ? AT[k][15:0] ^ 16'hA5C3 : 16'h0000);
      check(r, TT[k] == 6);
    end
    $display("test map done");
    bus(1'b0, 32'h50, 0);
    check(q, 32'h01);
    acc(1'b1, 18'h00480);
    check(s, 1'b0);
    acc(1'b1, 18'h00900);
    check(s, 1'b1);
    check(irq, 1'b0);
    bus(1'b1, 32'h54, 32'h04);
    @(negedge mclk);
    check(irq, 1'b1);
    bus(1'b0, 32'h50, 0);
    check(q, 32'h04);
    repeat (2) @(negedge mclk);
    check(irq, 1'b0);
    $display("test irq done");
    bus(1'b1, 32'h40, 32'h01);
    acc(1'b0, 18'h0047F);
    check(t, TGT_INFO);
    acc(1'b0, 18'h00480);
    check(t, TGT_RSVD);
    $display("test info done");
    bus(1'b1, 32'h68, 32'hFF);
    check(hresp, 1'b0);
    bus(1'b0, 32'h68, 0);
    check(q, 32'h5A);
    bus(1'b0, 32'h6C, 0);
    check(q, 32'h12);
    bus(1'b0, 32'h3FC, 0);
    check(q, 32'h00);
    bus(1'b0, 32'h4C, 0);
    check(q, 32'h01);
    check(mode_normal, 1'b1);
    $display("test ident done");
    bus(1'b1, 32'h44, 32'h01);
    @(negedge mclk);
    check(clk_src, SRC_OSC);
    k = 0;
    repeat (100) @(negedge mclk) k += tick;
    check(k, 10);
    $display("test clock done");
    bus(1'b1, 32'h44, 32'h03);
    osc_run <= 1'b0;
    r = 1'b0;
    for (k = 0; k < 1200 && !r; k++) @(negedge mclk) r = rst_req;
    check(r, 1'b1);
    bus(1'b0, 32'h50, 0);
    check(q[1], 1'b1);
    osc_run <= 1'b1;
    $display("test monitor done");
    mode_pin <= 1'b0;
    rst_n    <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(negedge mclk);
    check(mode_normal, 1'b0);
    bus(1'b0, 32'h4C, 0);
    check(q, 32'h00);
    $display("test mode done");
    report_and_stop();
  end
endmodule
`default_nettype wire
